// ===== hdl/config_index_data_port.v
// Purpose: configuration state machine, index/data ports and global
//          configuration registers of a multi-function I/O controller
// Assumes: host I/O cycles already decoded into one-cycle strobes
// Notes:   logical device register contents live outside this block
`timescale 1ns/1ps
`include "cfg_port_consts.vh"
module config_index_data_port #(
  parameter BLOCK_CYCLES = `BLOCK_CYCLES,
  parameter [7:0] IDENTITY_CODE = 8'hA5, // arbitrary value
  parameter [7:0] REVISION_CODE = 8'h01  // arbitrary value
) (
  // clock and power-on reset
  input  wire        CORE_CLK_I,
  input  wire        RST_N_I,
  // host bus reset and strap
  input  wire        HOST_BUS_RESET_N_I,
  input  wire        BASE_STRAP_I,
  // decoded host i/o cycle
  input  wire        IO_WR_I,
  input  wire        IO_RD_I,
  input  wire [15:0] IO_ADDR_I,
  input  wire [7:0]  IO_WDATA_I,
  output reg  [7:0]  IO_RDATA_O,
  output reg         IO_ACK_O,
  // logical device register access
  output reg  [7:0]  LDEV_SELECT_O,
  output reg  [7:0]  LDEV_INDEX_O,
  output reg  [7:0]  LDEV_WDATA_O,
  output reg         LDEV_WR_O,
  output reg         LDEV_RD_O,
  input  wire [7:0]  LDEV_RDATA_I,
  // state and global settings
  output reg         CONFIG_MODE_O,
  output reg         LDEV_RESET_O,
  output reg  [7:0]  POWER_CONTROL_O,
  output reg  [7:0]  POWER_MGMT_O,
  output reg  [7:0]  OSC_SETTING_O,
  output reg  [15:0] PORT_BASE_O
);
  localparam ST_RUN = 1'b0;
  localparam ST_CFG = 1'b1;

  // global register bank: indices below 0x30 are global
  function is_global;
    input [7:0] idx;
    begin
      is_global = (idx < 8'h30);
    end
  endfunction

  wire        host_ready;
  reg         state;
  reg         next_state;
  reg  [7:0]  index;
  reg         hbr_q;
  reg         hard_rst_pend;
  reg  [7:0]  global_rd;
  wire        cfg_hit;
  wire        data_hit;
  wire        hard_event;
  wire        soft_event;
  wire        wr_ok;
  wire        rd_ok;

  // ****************************************************************
  // power-on hold-off
  // ****************************************************************
  access_blocker #(
    .CYCLES (BLOCK_CYCLES),
    .CW     (32)
  ) u_blocker (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .ready_o (host_ready)
  );

  // ****************************************************************
  // decode and qualification
  // ****************************************************************
  // accesses are dropped, not stalled, while blocked or in reset
  assign wr_ok = IO_WR_I && host_ready && HOST_BUS_RESET_N_I;
  assign rd_ok = IO_RD_I && host_ready && HOST_BUS_RESET_N_I;
  assign cfg_hit  = (IO_ADDR_I == PORT_BASE_O);
  assign data_hit = (IO_ADDR_I == PORT_BASE_O + 16'h0001);
  assign hard_event = hbr_q && !HOST_BUS_RESET_N_I;
  assign soft_event = wr_ok && state == ST_CFG && data_hit &&
                      index == `IDX_CONFIG_CONTROL &&
                      IO_WDATA_I[`SOFT_RESET_BIT];

  // ****************************************************************
  // run / configuration state machine
  // ****************************************************************
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (wr_ok && cfg_hit && IO_WDATA_I == `KEY_ENTER)
          next_state = ST_CFG;
      end
      ST_CFG: begin
        if (wr_ok && cfg_hit && IO_WDATA_I == `KEY_EXIT)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
  end

  // ****************************************************************
  // global read mux
  // ****************************************************************
  always @* begin
    case (index)
      `IDX_LDEV_SELECT:     global_rd = LDEV_SELECT_O;
      `IDX_DEVICE_IDENTITY: global_rd = IDENTITY_CODE;
      `IDX_DEVICE_REVISION: global_rd = REVISION_CODE;
      `IDX_POWER_CONTROL:   global_rd = POWER_CONTROL_O;
      `IDX_POWER_MGMT:      global_rd = POWER_MGMT_O;
      `IDX_OSC_SETTING:     global_rd = OSC_SETTING_O;
      `IDX_PORT_BASE_LOW:   global_rd = PORT_BASE_O[7:0];
      `IDX_PORT_BASE_HIGH:  global_rd = PORT_BASE_O[15:8];
      default:              global_rd = 8'h00;
    endcase
  end

  // ****************************************************************
  // host bus reset edge and power-on hard reset pending flag
  // ****************************************************************
  // strap is taken by a clocked process, never under async reset
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hbr_q         <= 1'b1;
      hard_rst_pend <= 1'b1;
    end else begin
      hbr_q         <= HOST_BUS_RESET_N_I;
      hard_rst_pend <= 1'b0;
    end
  end

  // ****************************************************************
  // state, index and global registers
  // ****************************************************************
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state           <= ST_RUN;
      index           <= 8'h00;
      LDEV_SELECT_O   <= `RST_LDEV_SELECT;
      POWER_CONTROL_O <= `RST_POWER_CONTROL;
      POWER_MGMT_O    <= `RST_POWER_MGMT;
      OSC_SETTING_O   <= `RST_OSC_SETTING;
      PORT_BASE_O     <= `BASE_STRAP0;
      CONFIG_MODE_O   <= 1'b0;
      LDEV_RESET_O    <= 1'b1;
      IO_RDATA_O      <= 8'h00;
      IO_ACK_O        <= 1'b0;
      LDEV_SELECT_O   <= 8'h00;
      LDEV_INDEX_O    <= 8'h00;
      LDEV_WDATA_O    <= 8'h00;
      LDEV_WR_O       <= 1'b0;
      LDEV_RD_O       <= 1'b0;
    end else begin
      IO_ACK_O  <= 1'b0;
      LDEV_WR_O <= 1'b0;
      LDEV_RD_O <= 1'b0;
      LDEV_RESET_O <= 1'b0;
      if (hard_rst_pend || hard_event) begin
        // hard reset: run state, devices off, strap picks base
        state           <= ST_RUN;
        index           <= 8'h00;
        LDEV_SELECT_O   <= `RST_LDEV_SELECT;
        POWER_CONTROL_O <= `RST_POWER_CONTROL;
        POWER_MGMT_O    <= `RST_POWER_MGMT;
        OSC_SETTING_O   <= `RST_OSC_SETTING;
        PORT_BASE_O     <= BASE_STRAP_I ? `BASE_STRAP1
                                        : `BASE_STRAP0;
        LDEV_RESET_O    <= 1'b1;
        CONFIG_MODE_O   <= 1'b0;
      end else if (soft_event) begin
        // soft reset keeps mode and port base; devices go back to reset
        LDEV_SELECT_O   <= `RST_LDEV_SELECT;
        POWER_CONTROL_O <= `RST_POWER_CONTROL;
        POWER_MGMT_O    <= `RST_POWER_MGMT;
        OSC_SETTING_O   <= `RST_OSC_SETTING;
        LDEV_RESET_O    <= 1'b1;
        IO_ACK_O        <= 1'b1;
      end else begin
        state         <= next_state;
        CONFIG_MODE_O <= (next_state == ST_CFG);
        if (wr_ok && cfg_hit) begin
          IO_ACK_O <= 1'b1;
          // the config port doubles as index port in configuration
          // device index follows at once so a read sees the new index
          if (state == ST_CFG && IO_WDATA_I != `KEY_EXIT) begin
            index        <= IO_WDATA_I;
            LDEV_INDEX_O <= IO_WDATA_I;
          end
        end else if (wr_ok && data_hit && state == ST_CFG) begin
          IO_ACK_O <= 1'b1;
          if (is_global(index)) begin
            case (index)
              `IDX_LDEV_SELECT:    LDEV_SELECT_O   <= IO_WDATA_I;
              `IDX_POWER_CONTROL:  POWER_CONTROL_O <= IO_WDATA_I;
              `IDX_POWER_MGMT:     POWER_MGMT_O    <= IO_WDATA_I;
              `IDX_OSC_SETTING:    OSC_SETTING_O   <= IO_WDATA_I;
              `IDX_PORT_BASE_LOW:  PORT_BASE_O[7:0]  <= IO_WDATA_I;
              `IDX_PORT_BASE_HIGH: PORT_BASE_O[15:8] <= IO_WDATA_I;
              default: ;
            endcase
          end else begin
            LDEV_INDEX_O <= index;
            LDEV_WDATA_O <= IO_WDATA_I;
            LDEV_WR_O    <= 1'b1;
          end
        end else if (rd_ok && state == ST_CFG && (cfg_hit || data_hit)) begin
          IO_ACK_O <= 1'b1;
          if (cfg_hit)
            IO_RDATA_O <= index;
          else if (is_global(index))
            IO_RDATA_O <= global_rd;
          else begin
            IO_RDATA_O   <= LDEV_RDATA_I;
            LDEV_INDEX_O <= index;
            LDEV_RD_O    <= 1'b1;
          end
        end
      end
    end
  end
endmodule // config_index_data_port

// ===== hdl/cfg_port_consts.vh
// Purpose: constants for the configuration index/data port block
// Assumes: 40 MHz core clock
// Notes:   offsets are configuration indices, not bus addresses
`ifndef CFG_PORT_CONSTS_VH
`define CFG_PORT_CONSTS_VH
// ****************************************************************
// register indices
// ****************************************************************
`define IDX_CONFIG_CONTROL   8'h02
`define IDX_RESERVED_ZERO    8'h03
`define IDX_LDEV_SELECT      8'h07
`define IDX_DEVICE_IDENTITY  8'h20
`define IDX_DEVICE_REVISION  8'h21
`define IDX_POWER_CONTROL    8'h22
`define IDX_POWER_MGMT       8'h23
`define IDX_OSC_SETTING      8'h24
`define IDX_PORT_BASE_LOW    8'h26
`define IDX_PORT_BASE_HIGH   8'h27
// ****************************************************************
// fields, keys and reset values
// ****************************************************************
`define SOFT_RESET_BIT       0
`define KEY_ENTER            8'h55
`define KEY_EXIT             8'hAA
`define RST_CONFIG_CONTROL   8'h00
`define RST_LDEV_SELECT      8'h00
`define RST_POWER_CONTROL    8'h00
`define RST_POWER_MGMT       8'h00
`define RST_OSC_SETTING      8'h44
`define BASE_STRAP0          16'h002E
`define BASE_STRAP1          16'h004E
// ****************************************************************
// timing
// ****************************************************************
`define CLK_FREQ_HZ          40000000
`define BLOCK_TIME_US        500
`define BLOCK_CYCLES ((`CLK_FREQ_HZ / 1000000) * `BLOCK_TIME_US)
`endif

// ===== hdl/access_blocker.v
// Purpose: holds off host access for a fixed time after power-on
// Assumes: RST_N is the power-on reset, asynchronous active low
// Notes:   counts once; host bus reset does not restart it
`timescale 1ns/1ps
module access_blocker #(
  parameter CYCLES = 20000,
  parameter CW     = 16
) (
  // clock and reset
  input  wire clk_i,
  input  wire rst_n_i,
  // status
  output reg  ready_o
);
  reg [CW-1:0] count;

  // ****************************************************************
  // power-on hold-off counter
  // ****************************************************************
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count   <= {CW{1'b0}};
      ready_o <= 1'b0;
    end else if (!ready_o) begin
      if (count == CYCLES[CW-1:0] - 1'b1) ready_o <= 1'b1;
      count <= count + 1'b1;
    end
  end
endmodule // access_blocker

// ===== bench/ldev_regs_model.sv
// Purpose: logical device register file behind the block
// Assumes: the write pulse carries index and data together
// Notes:   read data follows the index with no delay
`timescale 1ns/1ps
module ldev_regs_model (
  // clock
  input  wire       clk_i,
  // register access from the block
  input  wire [7:0] idx_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  output wire [7:0] rdata_o
);
  reg [7:0] mem [0:255];
  // store on the write pulse, answer at once so reads need no wait
  always @(posedge clk_i) begin
    if (wr_i) mem[idx_i] <= wdata_i;
  end
  assign rdata_o = mem[idx_i];
endmodule // ldev_regs_model

// ===== bench/config_index_data_port_asserts.sv
// Purpose: port-level checks of the configuration port block
// Assumes: one clock domain, single-cycle host strobes
// Notes:   keeps its own copy of the index to judge data accesses
`timescale 1ns/1ps
module config_index_data_port_asserts #(
  parameter       BLOCK_CYCLES  = 16,
  parameter [7:0] IDENTITY_CODE = 8'h3C
) (
  input wire        CORE_CLK_I, RST_N_I, HOST_BUS_RESET_N_I,
  input wire        IO_WR_I, IO_RD_I, IO_ACK_O, LDEV_WR_O,
  input wire        CONFIG_MODE_O, BASE_STRAP_I,
  input wire [15:0] IO_ADDR_I, PORT_BASE_O,
  input wire [7:0]  IO_WDATA_I, IO_RDATA_O, LDEV_SELECT_O,
  input wire [7:0]  LDEV_WDATA_O, OSC_SETTING_O
);
  reg [15:0] cnt;
  reg        hr_q;
  reg [7:0]  idx;
  // margin past hold-off and host reset avoids edge-exact guesses
  wire ok = (cnt > BLOCK_CYCLES + 2) && HOST_BUS_RESET_N_I && hr_q;
  wire at_cfg = (IO_ADDR_I == PORT_BASE_O);
  wire at_dat = (IO_ADDR_I == PORT_BASE_O + 16'h0001);
  // edges since release, host reset history, index copy
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cnt  <= 16'h0000;
      hr_q <= 1'b0;
      idx  <= 8'h00;
    end else begin
      if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
      hr_q <= HOST_BUS_RESET_N_I;
      if (hr_q && !HOST_BUS_RESET_N_I)
        idx <= 8'h00;
      else if (ok && IO_WR_I && at_cfg && CONFIG_MODE_O &&
               IO_WDATA_I != 8'hAA)
        idx <= IO_WDATA_I;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_key(k); ok && IO_WR_I && at_cfg && IO_WDATA_I == k; endsequence
  sequence s_dwr(i); ok && IO_WR_I && at_dat && CONFIG_MODE_O && idx == i;
  endsequence
  sequence s_drd(i); ok && IO_RD_I && at_dat && CONFIG_MODE_O && idx == i;
  endsequence
  sequence s_hard; $fell(HOST_BUS_RESET_N_I) ##1 !HOST_BUS_RESET_N_I;
  endsequence
  property p_enter; (s_key(8'h55) ##0 !CONFIG_MODE_O) |=>
    CONFIG_MODE_O && IO_ACK_O; endproperty
  a_enter: assert property (p_enter) else $error("key 55 ignored");
  property p_exit; (s_key(8'hAA) ##0 CONFIG_MODE_O) |=> !CONFIG_MODE_O;
  endproperty
  a_exit: assert property (p_exit) else $error("key AA ignored");
  property p_deaf; (IO_WR_I || IO_RD_I) && at_dat && !CONFIG_MODE_O
    |=> !IO_ACK_O; endproperty
  a_deaf: assert property (p_deaf) else $error("data port in run");
  property p_hold; cnt < BLOCK_CYCLES - 2 |-> !IO_ACK_O; endproperty
  a_hold: assert property (p_hold) else $error("ack in hold-off");
  property p_dack; ok && (IO_WR_I || IO_RD_I) && at_dat && CONFIG_MODE_O
    |=> IO_ACK_O; endproperty
  a_dack: assert property (p_dack) else $error("data port deaf");
  property p_lwr; LDEV_WR_O |-> $past(IO_WR_I) &&
    LDEV_WDATA_O == $past(IO_WDATA_I); endproperty
  a_lwr: assert property (p_lwr) else $error("bad device write");
  property p_rsvd; s_drd(8'h03) |=> IO_RDATA_O == 8'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved not zero");
  property p_ident; s_drd(8'h20) |=> IO_RDATA_O == IDENTITY_CODE;
  endproperty
  a_ident: assert property (p_ident) else $error("identity wrong");
  property p_blo; s_dwr(8'h26) |=> PORT_BASE_O[7:0] == $past(IO_WDATA_I);
  endproperty
  a_blo: assert property (p_blo) else $error("base low not taken");
  property p_soft; (s_dwr(8'h02) ##0 IO_WDATA_I[0]) |-> ##[1:2]
    (OSC_SETTING_O == 8'h44 && LDEV_SELECT_O == 8'h00); endproperty
  a_soft: assert property (p_soft) else $error("soft reset lost");
  property p_hard; s_hard |=> !CONFIG_MODE_O && LDEV_SELECT_O == 8'h00 &&
    PORT_BASE_O == (BASE_STRAP_I ? 16'h004E : 16'h002E); endproperty
  a_hard: assert property (p_hard) else $error("hard reset");
endmodule // config_index_data_port_asserts

// ===== bench/tb_config_index_data_port.sv
// Purpose: self-checking bench for the configuration port block
// Assumes: hold-off shortened to 16 cycles
// Notes:   random data from a fixed-seed xorshift
`timescale 1ns/1ps
module tb_config_index_data_port;
  localparam BC = 16;
  reg         clk, rst_n, hr_n, strap, wr, rd;
  reg  [15:0] addr, b;
  reg  [7:0]  wdata, r, v;
  wire [7:0]  rdata, lsel, lidx, lwd, lrd, pc, pm, osc;
  wire        ack, lwr, cfg, lrst, lrdp;
  wire [15:0] base;
  reg  [31:0] seed = 32'h000183B6;
  integer     n_errors = 0, n_compared = 0, i;
  config_index_data_port #(.BLOCK_CYCLES(BC), .IDENTITY_CODE(8'h3C),
    .REVISION_CODE(8'h61)) uut ( // codes arbitrary
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .HOST_BUS_RESET_N_I(hr_n),
    .BASE_STRAP_I(strap), .IO_WR_I(wr), .IO_RD_I(rd), .IO_ADDR_I(addr),
    .IO_WDATA_I(wdata), .IO_RDATA_O(rdata), .IO_ACK_O(ack),
    .LDEV_SELECT_O(lsel), .LDEV_INDEX_O(lidx), .LDEV_WDATA_O(lwd),
    .LDEV_WR_O(lwr), .LDEV_RD_O(lrdp), .LDEV_RDATA_I(lrd),
    .CONFIG_MODE_O(cfg), .LDEV_RESET_O(lrst), .POWER_CONTROL_O(pc),
    .POWER_MGMT_O(pm), .OSC_SETTING_O(osc), .PORT_BASE_O(base));
  ldev_regs_model ldev (.clk_i(clk), .idx_i(lidx), .wdata_i(lwd),
    .wr_i(lwr), .rdata_o(lrd));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [15:0] base_of(input s);
    base_of = s ? 16'h004E : 16'h002E;
  endfunction
  task chk(input [15:0] seen, input [15:0] exp, input [63:0] what);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // one host cycle; an idle edge first keeps strobes single
  task io(input w, input [15:0] a, input [7:0] d, input e_ack);
    begin
      @(posedge clk);
      #1 {wr, rd, addr, wdata} = {w, !w, a, d};
      @(posedge clk);
      #1 {wr, rd} = 2'b00;
      chk(ack, e_ack, "ack");
    end
  endtask
  task put(input [7:0] x, input [7:0] d);
    begin
      io(1, b, x, 1);
      io(1, b + 16'h0001, d, 1);
    end
  endtask
  task get(input [7:0] x, input [7:0] e);
    begin
      io(1, b, x, 1);
      io(0, b + 16'h0001, 8'h00, 1);
      chk(rdata, e, "rdata");
    end
  endtask
  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // free-running clock and a watchdog against hangs
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #200000;
    n_errors = n_errors + 1;
    results;
  end
  // main sequence
  initial begin
    {rst_n, hr_n, strap, wr, rd, addr, wdata} = {5'b01000, 24'h000000};
    b = base_of(0);
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    io(1, b, 8'h55, 0);
    chk(cfg, 0, "mode");
    repeat (BC + 4) @(posedge clk);
    io(1, b, 8'h55, 1);
    chk(cfg, 1, "mode");
    get(8'h03, 8'h00);
    put(8'h03, 8'hFF);
    get(8'h03, 8'h00);
    get(8'h20, 8'h3C);
    get(8'h21, 8'h61);
    $display("test fixed registers done");
    for (i = 8'h22; i < 8'h26; i = i + 1) begin
      seed = xs(seed);
      r = seed[7:0];
      put(i[7:0], r);
      get(i[7:0], (i == 8'h25) ? 8'h00 : r);
      v = (i == 8'h22) ? pc : (i == 8'h23) ? pm : osc;
      if (i < 8'h25) chk(v, r, "setting");
    end
    put(8'h07, 8'h03);
    chk(lsel, 8'h03, "select");
    seed = xs(seed);
    v = {2'b11, seed[13:8]};
    put(v, seed[7:0]);
    put(v ^ 8'h01, ~seed[7:0]);
    get(v, seed[7:0]);
    chk(lrdp, 1, "devread");
    put(8'h02, 8'h01);
    chk(lrst, 1, "devreset");
    repeat (2) @(posedge clk);
    #1 chk(osc, 8'h44, "osc");
    chk(lsel, 8'h00, "select");
    $display("test global and device access done");
    put(8'h26, 8'h60);
    b = 16'h0060;
    put(8'h27, 8'h01);
    b = 16'h0160;
    chk(base, b, "base");
    io(1, b, 8'hAA, 1);
    chk(cfg, 0, "mode");
    io(0, b + 16'h0001, 8'h00, 0);
    io(1, 16'h002E, 8'h55, 0);
    io(1, b, 8'h55, 1);
    $display("test relocation done");
    strap = 1'b1;
    @(posedge clk);
    #1 hr_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(cfg, 0, "mode");
    chk(base, base_of(1), "base");
    chk(lsel, 8'h00, "select");
    hr_n = 1'b1;
    b = base_of(1);
    repeat (3) @(posedge clk);
    io(1, b, 8'h55, 1);
    $display("test hard reset done");
    results;
  end
endmodule // tb_config_index_data_port
bind config_index_data_port config_index_data_port_asserts #(
  .BLOCK_CYCLES(BLOCK_CYCLES), .IDENTITY_CODE(IDENTITY_CODE)) chk_i (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
  .HOST_BUS_RESET_N_I(HOST_BUS_RESET_N_I), .BASE_STRAP_I(BASE_STRAP_I),
  .IO_WR_I(IO_WR_I), .IO_RD_I(IO_RD_I), .IO_ACK_O(IO_ACK_O),
  .LDEV_WR_O(LDEV_WR_O), .CONFIG_MODE_O(CONFIG_MODE_O),
  .IO_ADDR_I(IO_ADDR_I), .PORT_BASE_O(PORT_BASE_O),
  .IO_WDATA_I(IO_WDATA_I), .IO_RDATA_O(IO_RDATA_O),
  .LDEV_SELECT_O(LDEV_SELECT_O), .LDEV_WDATA_O(LDEV_WDATA_O),
  .OSC_SETTING_O(OSC_SETTING_O));
